// file: swdt_pkg.sv
// Package for the system watchdog timer: constants, types and encodings.
// Assumes a single 10 MHz clock domain.
package swdt_pkg;

  // Clock rate and unit timing
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Firmware call selection codes
  localparam logic [7:0] FUNC_CODE = 8'h6f;
  localparam logic [7:0] SUBF_SET_PERIOD = 8'h02;

  // Time-out value width and reset value
  localparam int unsigned TOUT_W = 8;
  localparam logic [7:0] TOUT_RST = 8'h00;

  // Unit-select encodings: seconds or minutes per count step
  localparam int unsigned UNIT_SEC_S = 1;
  localparam int unsigned UNIT_MIN_S = 60;

  // Cycles per unit step, derived from the rate
  localparam int unsigned SEC_CYC_DEF = UNIT_SEC_S * CLK_HZ;
  localparam int unsigned MIN_CYC_DEF = UNIT_MIN_S * CLK_HZ;

  // Prescaler width, large enough for a minute of cycles
  localparam int unsigned PRE_W = 30;

  // Reset synchroniser depth
  localparam int unsigned SYNC_N = 2;

  // Expiry action selection
  typedef enum logic {
    SWDT_ACT_RESET,
    SWDT_ACT_NMI
  } swdt_act_t;

  // Command from the firmware call path
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [7:0] subf;
    logic [7:0] value;
  } swdt_cmd_t;

endpackage

// file: swdt_pulse.sv
// Expiry pulse stretcher: holds the selected expiry output for a fixed
// number of cycles. Assumes a trigger on the same clock as mclk.
`timescale 1ns/1ps
`default_nettype none
module swdt_pulse #(
  parameter int unsigned LEN = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Trigger and stretched output
  input wire logic trig,
  output logic pulse
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // Load on trigger, count down to zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (trig) begin
      cnt_nxt = 8'(LEN);
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign pulse = (cnt_r != 8'h00);

endmodule
`default_nettype wire

// file: swdt_top.sv
// System watchdog timer: software loads an 8-bit time-out through a
// firmware call; countdown expiry forces a cold reset or an NMI.
// Assumes the firmware call decoder on mclk drives the command strobe.
//
// Functional notes
// [RULE1] Function 6FH, sub-function 2 loads a new time-out value.
// [RULE2] A nonzero loaded value starts the countdown toward zero.
// [RULE3] Countdown reaching zero resets the system. The code gives an NMI instead, with no reset, when act_nmi selects it.
// [RULE4] Expiry gives either a cold reset or an NMI, by selection.
// [RULE5] Software reloads before expiry; each reload restarts the countdown.
// [RULE6] Loading zero disables the watchdog; no expiry follows.
// [RULE7] Step duration follows a separate unit-select setting.
// [RULE8] Software refreshes with at least 10% margin below the time-out.
// [RULE9] Software loads zero before a supervised program ends.
// [RULE10] Time-out register is 8 bits and zero after reset.
`timescale 1ns/1ps
`default_nettype none
module swdt_top #(
  parameter int unsigned SEC_CYC = swdt_pkg::SEC_CYC_DEF,
  parameter int unsigned MIN_CYC = swdt_pkg::MIN_CYC_DEF,
  parameter int unsigned PULSE_LEN = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Firmware call command, same clock domain
  input wire swdt_pkg::swdt_cmd_t cmd,
  // Setup options, static levels from setup storage
  input wire logic unit_min,
  input wire logic act_nmi,
  // Expiry outputs
  output logic cold_reset,
  output logic nmi,
  // Status
  output logic running,
  output logic [7:0] count_out
);

  // Reset release through two flip-flops
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // Setup option levels pass two flip-flops
  logic [1:0] unit_s1_r;
  logic [1:0] opt_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unit_s1_r <= 2'b00;
      opt_r <= 2'b00;
    end else begin
      unit_s1_r <= {act_nmi, unit_min};
      opt_r <= unit_s1_r;
    end
  end

  // Decode a period-setting call
  function automatic logic is_set_period(swdt_pkg::swdt_cmd_t c);
    return c.valid && (c.func == swdt_pkg::FUNC_CODE) &&
      (c.subf == swdt_pkg::SUBF_SET_PERIOD);
  endfunction

  logic load;
  assign load = is_set_period(cmd); // [RULE1]

  // Countdown state
  logic [7:0] tout_r;
  logic [7:0] tout_nxt;
  logic [swdt_pkg::PRE_W-1:0] pre_r;
  logic [swdt_pkg::PRE_W-1:0] pre_nxt;
  logic run_r;
  logic run_nxt;
  logic expire;
  logic [swdt_pkg::PRE_W-1:0] step_max;

  // Unit select picks the step length
  assign step_max = opt_r[0] ? swdt_pkg::PRE_W'(MIN_CYC - 1) :
    swdt_pkg::PRE_W'(SEC_CYC - 1); // [RULE7]

  always_comb begin
    tout_nxt = tout_r;
    pre_nxt = pre_r;
    run_nxt = run_r;
    expire = 1'b0;
    if (load) begin
      tout_nxt = cmd.value; // [RULE5]
      pre_nxt = '0;
      run_nxt = (cmd.value != 8'h00); // [RULE2] [RULE6]
    end else if (run_r) begin
      if (pre_r >= step_max) begin
        pre_nxt = '0;
        tout_nxt = tout_r - 8'h01;
        if (tout_r == 8'h01) begin
          run_nxt = 1'b0;
          expire = 1'b1; // [RULE3]
        end
      end else begin
        pre_nxt = pre_r + swdt_pkg::PRE_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tout_r <= swdt_pkg::TOUT_RST; // [RULE10]
      pre_r <= '0;
      run_r <= 1'b0;
    end else begin
      tout_r <= tout_nxt;
      pre_r <= pre_nxt;
      run_r <= run_nxt;
    end
  end

  // Route expiry to the selected action
  logic rst_trig;
  logic nmi_trig;
  assign rst_trig = expire && (opt_r[1] == swdt_pkg::SWDT_ACT_RESET);
  assign nmi_trig = expire && (opt_r[1] == swdt_pkg::SWDT_ACT_NMI); // [RULE4]

  swdt_pulse #(
    .LEN(PULSE_LEN)
  ) u_rst_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .trig(rst_trig),
    .pulse(cold_reset)
  );

  swdt_pulse #(
    .LEN(PULSE_LEN)
  ) u_nmi_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .trig(nmi_trig),
    .pulse(nmi)
  );

  assign running = run_r;
  assign count_out = tout_r;

  // Checks
  load_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
    load && cmd.value == 8'h00 |=> !running ##1 !cold_reset && !nmi)
    else $error("zero load did not disable");
  load_run_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    load && cmd.value != 8'h00 |=> running && count_out == $past(cmd.value))
    else $error("nonzero load did not start");
  reload_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    load |=> pre_r == '0 && tout_r == $past(cmd.value))
    else $error("reload did not restart");
  expire_out_a: assert property (@(posedge mclk) // [RULE4]
    disable iff (!rst_n) expire |=> (cold_reset ^ nmi))
    else $error("expiry gave no single action");
  expire_when_a: assert property (@(posedge mclk) // [RULE3]
    disable iff (!rst_n) expire |-> (running && count_out == 8'h01)
    ##1 (!running && count_out == 8'h00))
    else $error("expiry at wrong count");
  idle_quiet_a: assert property (@(posedge mclk) // [RULE6]
    disable iff (!rst_n) !running && !load |=> !running && $stable(count_out))
    else $error("disabled watchdog moved");
  step_unit_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
    run_r && !load && pre_r < step_max |=> tout_r == $past(tout_r))
    else $error("count stepped early");
  func_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    cmd.valid && cmd.func != swdt_pkg::FUNC_CODE |-> !load)
    else $error("wrong function accepted");
  reset_zero_a: assert property (@(posedge mclk) // [RULE10]
    $rose(rst_n) |-> tout_r == 8'h00 && !running)
    else $error("time-out not zero after reset");

endmodule
`default_nettype wire

// file: swdt_host.sv
// Host software model: issues firmware calls on the command port.
// Assumes mclk from the bench; calls launch at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module swdt_host (
  // Clock
  input wire logic mclk,
  // Command to the watchdog
  output var swdt_pkg::swdt_cmd_t cmd
);
  initial cmd = '0;
  // One-cycle call, then released lines show the inverse pattern
  task automatic call(input logic [7:0] f, s, v);
    @(negedge mclk);
    cmd <= {1'b1, f, s, v};
    @(negedge mclk);
    cmd <= {1'b0, ~f, ~s, ~v};
  endtask
  // Period-set call, also used to refresh or disable
  task automatic load(input logic [7:0] v);
    call(swdt_pkg::FUNC_CODE, swdt_pkg::SUBF_SET_PERIOD, v);
  endtask
endmodule
`default_nettype wire

// file: tb_system_watchdog_timer.sv
// Self-checking bench for the watchdog with short unit steps.
// Assumes swdt_host drives commands; options driven at falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
  failures++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_system_watchdog_timer;
  localparam int SEC = 4;
  localparam int MIN = 8;
  localparam int PLEN = 3;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic unit_min = 1'b0;
  logic act_nmi = 1'b0;
  logic cold_reset, nmi, running;
  logic [7:0] count_out;
  swdt_pkg::swdt_cmd_t cmd;
  int failures = 0;
  int checked = 0;
  swdt_host i_host (.mclk(mclk), .cmd(cmd));
  swdt_top #(.SEC_CYC(SEC), .MIN_CYC(MIN), .PULSE_LEN(PLEN)) i_dut (
    .mclk(mclk), .resetn(resetn), .cmd(cmd), .unit_min(unit_min),
    .act_nmi(act_nmi), .cold_reset(cold_reset), .nmi(nmi),
    .running(running), .count_out(count_out));
  // 10 MHz clock
  always #50 mclk = ~mclk;
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // No expiry output for a number of cycles
  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(negedge mclk);
      `CHK("no_expiry", 1'b0, cold_reset | nmi)
    end
  endtask
  // Load, then check the answer and the expiry window, pulse and kind
  task automatic run_out(input logic [7:0] v, input logic um, an);
    int n;
    int step;
    n = 0;
    step = um ? MIN : SEC;
    @(negedge mclk);
    unit_min = um;
    act_nmi = an;
    repeat (4) @(negedge mclk);
    i_host.load(v);
    @(negedge mclk);
    `CHK("count_out", v, count_out)
    `CHK("running", 1'b1, running)
    while (!(cold_reset | nmi) && n < v * step + 8) begin
      @(negedge mclk);
      n++;
    end
    `CHK("delay_ok", 1'b1, n >= v * step - 1 && n <= v * step + 3)
    `CHK("nmi", an, nmi)
    `CHK("cold_reset", ~an, cold_reset)
    n = 0;
    while ((cold_reset | nmi) && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK("pulse_len", PLEN, n)
    `CHK("running_end", 1'b0, running)
  endtask
  // Main sequence
  initial begin
    void'($urandom(82));
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK("rst_count", 8'h00, count_out)
    `CHK("rst_running", 1'b0, running)
    quiet(20);
    // Other function or sub-function codes do nothing
    i_host.call(8'h6e, 8'h02, 8'h05);
    i_host.call(8'h6f, 8'h01, 8'h05);
    quiet(30);
    `CHK("ignored", 1'b0, running)
    // Random loads over both units and both actions
    for (int i = 0; i < 8; i++) begin
      run_out(8'($urandom_range(1, 5)), 1'($urandom), 1'($urandom));
    end
    run_out(8'hff, 1'b0, 1'b1);
    run_out(8'h01, 1'b1, 1'b0);
    run_out(8'h02, 1'b0, 1'b0);
    run_out(8'h02, 1'b1, 1'b1);
    // Reset in mid-countdown clears the time-out and stops it
    i_host.load(8'h05);
    repeat (3) @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    `CHK("mid_rst_count", 8'h00, count_out)
    `CHK("mid_rst_running", 1'b0, running)
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    quiet(60);
    `CHK("after_rst_running", 1'b0, running)
    // Refresh with margin keeps it from expiring
    i_host.load(8'h03);
    repeat (6) begin
      quiet(8);
      i_host.load(8'h03);
    end
    `CHK("refreshed", 8'h03, count_out)
    // Disable before the program ends
    i_host.load(8'h00);
    quiet(60);
    `CHK("disabled", 1'b0, running)
    conclude();
  end
  // Watchdog on the bench itself
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
